/* inc/pcg_pkg.sv */
// constants and carrier types for the peripheral clock gating block
// ----------------------------------------------------------------
// Overview of operation
// - first enable bit 3 clocks sync serial one
// - first enable bit 2 clocks sync serial zero
// - first enable bit 0 clocks the modulator
// - second enable bits 14..12 clock interval timers
// - second enable bits 7..4 clock second timer
// - second enable bits 3..0 clock first timer
// - stop mode shuts clocks unless stop-keep set
// - stop-keep only effective with enable set
// - stop-keep bits 15,14 for comparators B, A
// - stop-keep bits 13,12 for dacs one, zero
// - stop-keep bit 10 for the adc
// - stop-keep bit 6 for two-wire module
// - stop-keep bits 5..2 for serial modules
// - stop-keep bit 0 for the modulator
// - accesses to gated peripheral have no effect
// - kept peripheral interrupt wakes to run mode
// - disabled peripheral held stopped like stop mode
// - enable alone does not beat stop mode
// ----------------------------------------------------------------
package pcg_pkg;

   // ----------------------------------------------------------------
   // lanes and widths
   // ----------------------------------------------------------------
   localparam int unsigned LANES    = 32;
   localparam int unsigned REG_W    = 16;
   localparam int unsigned ADDR_W   = 12;
   localparam int unsigned DATA_W   = 32;

   // ----------------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] IDX_FIRST_ENABLE  = 12'h00c;
   localparam logic [ADDR_W-1:0] IDX_SECOND_ENABLE = 12'h00d;
   localparam logic [ADDR_W-1:0] IDX_FIRST_KEEP    = 12'h00e;
   localparam logic [ADDR_W-1:0] IDX_CLOCK_STATUS  = 12'h020;
   localparam logic [ADDR_W-1:0] IDX_WAKE_SOURCE   = 12'h021;
   localparam logic [ADDR_W-1:0] IDX_MODE_STATUS   = 12'h022;

   localparam logic [ADDR_W-1:0] ADDR_FIRST_ENABLE  = {IDX_FIRST_ENABLE[ADDR_W-3:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_SECOND_ENABLE = {IDX_SECOND_ENABLE[ADDR_W-3:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_FIRST_KEEP    = {IDX_FIRST_KEEP[ADDR_W-3:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CLOCK_STATUS  = {IDX_CLOCK_STATUS[ADDR_W-3:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_WAKE_SOURCE   = {IDX_WAKE_SOURCE[ADDR_W-3:0], 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MODE_STATUS   = {IDX_MODE_STATUS[ADDR_W-3:0], 2'b00};

   // ----------------------------------------------------------------
   // implemented bits and reset values
   // ----------------------------------------------------------------
   localparam logic [REG_W-1:0] MASK_FIRST_ENABLE  = 16'hf47d;
   localparam logic [REG_W-1:0] MASK_SECOND_ENABLE = 16'h70ff;
   localparam logic [REG_W-1:0] MASK_FIRST_KEEP    = 16'hf47d;
   localparam logic [REG_W-1:0] RST_FIRST_ENABLE   = 16'h0000;
   localparam logic [REG_W-1:0] RST_SECOND_ENABLE  = 16'h0000;
   localparam logic [REG_W-1:0] RST_FIRST_KEEP     = 16'h0000;
   localparam logic [REG_W-1:0] NO_TIMER_KEEP      = 16'h0000;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int unsigned BIT_MODULATOR        = 0;
   localparam int unsigned BIT_SYNC_SERIAL_ZERO = 2;
   localparam int unsigned BIT_SYNC_SERIAL_ONE  = 3;
   localparam int unsigned BIT_ASYNC_ZERO       = 4;
   localparam int unsigned BIT_ASYNC_ONE        = 5;
   localparam int unsigned BIT_TWO_WIRE         = 6;
   localparam int unsigned BIT_ADC              = 10;
   localparam int unsigned BIT_DAC_ZERO         = 12;
   localparam int unsigned BIT_DAC_ONE          = 13;
   localparam int unsigned BIT_COMPARATOR_A     = 14;
   localparam int unsigned BIT_COMPARATOR_B     = 15;
   localparam int unsigned BIT_FIRST_TIMER_LO   = 0;
   localparam int unsigned BIT_SECOND_TIMER_LO  = 4;
   localparam int unsigned BIT_INTERVAL_LO      = 12;
   localparam int unsigned BIT_MODE_STOP        = 0;
   localparam int unsigned BIT_MODE_WAKE        = 1;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic {
      MODE_RUN,
      MODE_STOP
   } pcg_mode_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } pcg_apb_req_t;

   typedef struct packed {
      logic              pready;
      logic [DATA_W-1:0] prdata;
      logic              pslverr;
   } pcg_apb_rsp_t;

endpackage

/* logic/pcg_lane.sv */
// one peripheral clock lane: registered clock enable, access gate, wake
`timescale 1ns/1ps
`default_nettype none
module pcg_lane
   import pcg_pkg::*;
(
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic enable,
   input  wire logic keep,
   input  wire logic stop_mode,
   input  wire logic access_req,
   input  wire logic irq,
   output logic      clk_en,
   output logic      access_ok,
   output logic      wake
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic run;
      logic acc;
      logic wk;
   } pcg_lane_st_t;

   pcg_lane_st_t st_r;
   pcg_lane_st_t st_nxt;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt     = st_r;
      // disabled lane is held stopped, exactly as in stop mode
      st_nxt.run = enable & (~stop_mode | keep);
      // access only reaches a peripheral that is clocked now
      st_nxt.acc = access_req & st_r.run;
      // only a lane still clocked in stop can raise the wake
      st_nxt.wk  = irq & st_r.run & stop_mode;
   end

   // enable changes only at an edge, so the downstream gate cell never slices a pulse
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign clk_en    = st_r.run;
   assign access_ok = st_r.acc;
   assign wake      = st_r.wk;

endmodule
`default_nettype wire

/* logic/pcg_top.sv */
// register file, stop mode control and lane array for peripheral clock gating
`timescale 1ns/1ps
`default_nettype none
module pcg_top
   import pcg_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          reset_n,
   input  wire pcg_apb_req_t  apb_req,
   output pcg_apb_rsp_t       apb_rsp,
   input  wire logic          stop_req,
   input  wire logic [LANES-1:0] periph_access,
   input  wire logic [LANES-1:0] periph_irq,
   output logic [LANES-1:0]   periph_clk_en,
   output logic [LANES-1:0]   periph_access_ok,
   output logic               stop_mode,
   output logic               wake_pulse
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [REG_W-1:0] first_enable;
      logic [REG_W-1:0] second_enable;
      logic [REG_W-1:0] first_keep;
      logic [LANES-1:0] wake_src;
      pcg_mode_t        mode;
      logic             woke;
      logic             wake_p;
      pcg_apb_rsp_t     rsp;
   } pcg_top_st_t;

   pcg_top_st_t st_r;
   pcg_top_st_t st_nxt;

   // ----------------------------------------------------------------
   // lane vectors
   // ----------------------------------------------------------------
   logic [LANES-1:0] lane_enable;
   logic [LANES-1:0] lane_keep;
   logic [LANES-1:0] lane_clk;
   logic [LANES-1:0] lane_acc;
   logic [LANES-1:0] lane_wake;
   logic             any_wake;

   // low half: first enable bits, high half: second enable bits
   assign lane_enable = {st_r.second_enable, st_r.first_enable};
   // timer lanes have no stop-keep here, so they always stop in stop mode
   assign lane_keep   = {NO_TIMER_KEEP, st_r.first_keep};
   assign any_wake    = |lane_wake;

   // ----------------------------------------------------------------
   // lane array
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         pcg_lane u_lane (
            .clock      (clock),
            .reset_n    (reset_n),
            .enable     (lane_enable[gi]),
            .keep       (lane_keep[gi]),
            .stop_mode  (st_r.mode == MODE_STOP),
            .access_req (periph_access[gi]),
            .irq        (periph_irq[gi]),
            .clk_en     (lane_clk[gi]),
            .access_ok  (lane_acc[gi]),
            .wake       (lane_wake[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   logic             acc_phase;
   logic             wr_commit;
   logic             hit;
   logic [DATA_W-1:0] rd_word;

   assign acc_phase = apb_req.psel & apb_req.penable;
   // a write lands only on the edge where the master sees pready
   assign wr_commit = acc_phase & st_r.rsp.pready & apb_req.pwrite;

   always_comb begin
      hit     = 1'b1;
      rd_word = '0;
      unique case (apb_req.paddr)
         ADDR_FIRST_ENABLE: begin
            rd_word = {16'h0000, st_r.first_enable};
         end
         ADDR_SECOND_ENABLE: begin
            rd_word = {16'h0000, st_r.second_enable};
         end
         ADDR_FIRST_KEEP: begin
            rd_word = {16'h0000, st_r.first_keep};
         end
         ADDR_CLOCK_STATUS: begin
            rd_word = lane_clk;
         end
         ADDR_WAKE_SOURCE: begin
            rd_word = st_r.wake_src;
         end
         ADDR_MODE_STATUS: begin
            rd_word[BIT_MODE_STOP] = (st_r.mode == MODE_STOP);
            rd_word[BIT_MODE_WAKE] = st_r.woke;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt        = st_r;
      st_nxt.wake_p = 1'b0;

      // one wait state: answer registered the cycle after access starts
      if (acc_phase && !st_r.rsp.pready) begin
         st_nxt.rsp.pready  = 1'b1;
         st_nxt.rsp.prdata  = apb_req.pwrite ? '0 : rd_word;
         st_nxt.rsp.pslverr = ~hit;
      end else begin
         st_nxt.rsp.pready  = 1'b0;
         st_nxt.rsp.prdata  = '0;
         st_nxt.rsp.pslverr = 1'b0;
      end

      // reserved bits never store, so they read back zero
      if (wr_commit && hit) begin
         unique case (apb_req.paddr)
            ADDR_FIRST_ENABLE: begin
               st_nxt.first_enable = apb_req.pwdata[REG_W-1:0] & MASK_FIRST_ENABLE;
            end
            ADDR_SECOND_ENABLE: begin
               st_nxt.second_enable = apb_req.pwdata[REG_W-1:0] & MASK_SECOND_ENABLE;
            end
            ADDR_FIRST_KEEP: begin
               st_nxt.first_keep = apb_req.pwdata[REG_W-1:0] & MASK_FIRST_KEEP;
            end
            ADDR_MODE_STATUS: begin
               // write one clears the wake flag; a new wake wins below
               if (apb_req.pwdata[BIT_MODE_WAKE]) begin
                  st_nxt.woke     = 1'b0;
                  st_nxt.wake_src = '0;
               end
            end
            default: begin
               st_nxt.woke = st_r.woke;
            end
         endcase
      end

      // stop mode control
      unique case (st_r.mode)
         MODE_RUN: begin
            // no stop entry while a wake is still on its way
            if (stop_req && !any_wake) begin
               st_nxt.mode = MODE_STOP;
            end
         end
         MODE_STOP: begin
            if (any_wake) begin
               st_nxt.mode     = MODE_RUN;
               st_nxt.wake_p   = 1'b1;
               st_nxt.woke     = 1'b1;
               // builds on the cleared value, so a clear in the same cycle keeps only new sources
               st_nxt.wake_src = st_nxt.wake_src | lane_wake;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         st_r.first_enable  <= RST_FIRST_ENABLE;
         st_r.second_enable <= RST_SECOND_ENABLE;
         st_r.first_keep    <= RST_FIRST_KEEP;
         st_r.wake_src      <= '0;
         st_r.mode          <= MODE_RUN;
         st_r.woke          <= 1'b0;
         st_r.wake_p        <= 1'b0;
         st_r.rsp           <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign apb_rsp          = st_r.rsp;
   assign periph_clk_en    = lane_clk;
   assign periph_access_ok = lane_acc;
   assign stop_mode        = (st_r.mode == MODE_STOP);
   assign wake_pulse       = st_r.wake_p;

endmodule
`default_nettype wire

/* tb/pcg_chk.sv */
// port checker for the peripheral clock gating block
`timescale 1ns/1ps
`default_nettype none
module pcg_chk
   import pcg_pkg::*;
(
   input wire logic             clock,
   input wire logic             reset_n,
   input wire pcg_apb_req_t     apb_req,
   input wire pcg_apb_rsp_t     apb_rsp,
   input wire logic             stop_req,
   input wire logic [LANES-1:0] periph_access,
   input wire logic [LANES-1:0] periph_irq,
   input wire logic [LANES-1:0] periph_clk_en,
   input wire logic [LANES-1:0] periph_access_ok,
   input wire logic             stop_mode,
   input wire logic             wake_pulse
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   AST_TIMER_STOP: assert property ($past(stop_mode) |-> periph_clk_en[31:16] == 16'h0)
      else $error("timer lane clocked in stop");
   AST_RESERVED_LANE: assert property ((periph_clk_en & ~{MASK_SECOND_ENABLE, MASK_FIRST_ENABLE}) == '0)
      else $error("reserved lane clocked");
   AST_ACCESS_GATED: assert property ((periph_access_ok & ~(periph_clk_en | $past(periph_clk_en))) == '0)
      else $error("access passed to gated lane");
   AST_ACCESS_CAUSE: assert property ((periph_access_ok & ~$past(periph_access)) == '0)
      else $error("access ok without request");
   AST_WAKE_EXIT: assert property (wake_pulse |-> !stop_mode && $past(stop_mode))
      else $error("wake pulse without leaving stop");
   AST_WAKE_ONCE: assert property (wake_pulse |=> !wake_pulse)
      else $error("wake pulse too long");
   AST_STOP_CAUSE: assert property ($rose(stop_mode) |-> $past(stop_req))
      else $error("stop entered without request");
   AST_READY_TIME: assert property ($rose(apb_req.penable) && apb_req.psel |-> ##1 apb_rsp.pready)
      else $error("pready late");
   AST_READY_ONCE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready too long");
   AST_ERR_READY: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
      else $error("pslverr without pready");
   COV_WAKE: cover property (wake_pulse);
   COV_STOP: cover property ($rose(stop_mode));
   COV_ERR: cover property (apb_rsp.pslverr);
endmodule
bind pcg_top pcg_chk u_pcg_chk (.clock(clock), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .stop_req(stop_req), .periph_access(periph_access), .periph_irq(periph_irq),
   .periph_clk_en(periph_clk_en), .periph_access_ok(periph_access_ok), .stop_mode(stop_mode),
   .wake_pulse(wake_pulse));
`default_nettype wire

/* tb/pcg_periph_model.sv */
// behavioural peripheral set sitting on the gated clock lanes
`timescale 1ns/1ps
`default_nettype none
module pcg_periph_model
   import pcg_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             reset_n,
   input  wire logic [LANES-1:0] periph_clk_en,
   input  wire logic [LANES-1:0] irq_arm,
   input  wire logic [LANES-1:0] access_want,
   output logic      [LANES-1:0] periph_access,
   output logic      [LANES-1:0] periph_irq
);
   assign periph_access = access_want;
   // a stopped peripheral has no clock, so it cannot raise anything
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         periph_irq <= '0;
      end else begin
         periph_irq <= irq_arm & periph_clk_en;
      end
   end
endmodule
`default_nettype wire

/* tb/tb_pcg_top.sv */
// self-checking bench for the peripheral clock gating block
`timescale 1ns/1ps
`default_nettype none
module tb_pcg_top
   import pcg_pkg::*;
;
   logic             clock;
   logic             reset_n;
   logic             stop_req;
   pcg_apb_req_t     req;
   pcg_apb_rsp_t     rsp;
   logic [LANES-1:0] clk_en, acc_ok, acc, irq, irq_arm, acc_want;
   logic             stop_mode, wake, err;
   logic [DATA_W-1:0] rd;
   int               err_total, checked;
   pcg_top u_pcg_top (.clock(clock), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp), .stop_req(stop_req),
      .periph_access(acc), .periph_irq(irq), .periph_clk_en(clk_en), .periph_access_ok(acc_ok),
      .stop_mode(stop_mode), .wake_pulse(wake));
   pcg_periph_model u_pcg_periph_model (.clock(clock), .reset_n(reset_n), .periph_clk_en(clk_en),
      .irq_arm(irq_arm), .access_want(acc_want), .periph_access(acc), .periph_irq(irq));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // idle cycle after release keeps one assignment per time step
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clock);
      req.penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      rd = rsp.prdata;
      err = rsp.pslverr;
      if (n >= 20) err_total++;
      req <= '0;
      @(posedge clock);
   endtask
   task automatic do_reset();
      reset_n <= 1'b0;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
   endtask
   task automatic set_en(input logic [LANES-1:0] v);
      apb(1'b1, ADDR_FIRST_ENABLE, {16'h0, v[15:0]});
      apb(1'b1, ADDR_SECOND_ENABLE, {16'h0, v[31:16]});
      repeat (2) @(posedge clock);
   endtask
   task automatic test_regs();
      logic [ADDR_W-1:0] regs [3];
      regs = '{ADDR_FIRST_ENABLE, ADDR_SECOND_ENABLE, ADDR_FIRST_KEEP};
      foreach (regs[i]) begin
         apb(1'b0, regs[i], '0);
         chk(rd, '0);
      end
      chk(clk_en, '0);
      apb(1'b0, 12'h0fc, '0);
      chk(err, 1'b1);
      chk(rd, '0);
   endtask
   task automatic test_lanes();
      logic [LANES-1:0] m;
      m = {MASK_SECOND_ENABLE, MASK_FIRST_ENABLE};
      acc_want <= '1;
      for (int i = 0; i < LANES; i++) begin
         if (m[i]) begin
            set_en(32'h1 << i);
            chk(clk_en, 32'h1 << i);
            chk(acc_ok, 32'h1 << i);
         end
      end
      acc_want <= '0;
      set_en(m);
      apb(1'b0, ADDR_CLOCK_STATUS, '0);
      chk(rd, m);
      apb(1'b0, ADDR_SECOND_ENABLE, '0);
      chk(rd, {16'h0, MASK_SECOND_ENABLE});
   endtask
   // the woken lane must be both enabled and kept
   task automatic test_stop(input logic [REG_W-1:0] en0, input logic [REG_W-1:0] keep, input int lane);
      int n;
      set_en({MASK_SECOND_ENABLE, en0});
      apb(1'b1, ADDR_FIRST_KEEP, {16'h0, keep});
      stop_req <= 1'b1;
      for (n = 0; n < 20 && stop_mode !== 1'b1; n++) @(posedge clock);
      repeat (2) @(posedge clock);
      chk(clk_en, {16'h0, en0 & keep});
      irq_arm <= 32'h1 << lane;
      for (n = 0; n < 20 && wake !== 1'b1; n++) @(posedge clock);
      chk(wake, 1'b1);
      stop_req <= 1'b0;
      irq_arm <= '0;
      repeat (3) @(posedge clock);
      chk(clk_en, {MASK_SECOND_ENABLE, en0});
      apb(1'b0, ADDR_MODE_STATUS, '0);
      chk(rd, 32'h2);
      apb(1'b0, ADDR_WAKE_SOURCE, '0);
      chk(rd, 32'h1 << lane);
      apb(1'b1, ADDR_MODE_STATUS, 32'h2);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      stop_req = 1'b0;
      req = '0;
      irq_arm = '0;
      acc_want = '0;
      err_total = 0;
      checked = 0;
      do_reset();
      test_regs();
      test_lanes();
      test_stop(16'hf47d, 16'h5459, 0);
      test_stop(16'hf47d, 16'ha024, 15);
      test_stop(16'h0404, 16'hf47d, 10);
      do_reset();
      test_regs();
      finish_test();
   end
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      finish_test();
   end
endmodule
`default_nettype wire
